// ---- hw/pmsq_sequencer.sv ----
/*
 * Operating-mode controller and power on/off sequencer, with its input
 * deglitchers and the wakeup-cause register.
 * Assumes analog comparators supply battery_above_* as logic levels and
 * that an outside register interface delivers single-cycle writes.
 */
`timescale 1ns/1ns
`default_nettype none

module pmsq_deglitch #(
  parameter logic [7:0] TICKS = 8'h20
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic tick,
  input  wire logic raw,
  output logic      level
);
  logic [2:0] sync_q, sync_d;
  logic [7:0] cnt_q, cnt_d;
  logic       level_q, level_d;

  always_comb begin
    sync_d  = {sync_q[1:0], raw};
    cnt_d   = cnt_q;
    level_d = level_q;
    // Stage two and three must agree before a change is trusted
    if ((sync_q[1] != sync_q[2]) || (sync_q[2] == level_q)) begin
      cnt_d = 8'h00;
    end else if (TICKS == 8'h00) begin
      level_d = sync_q[2];
    end else if (tick) begin
      if (cnt_q == TICKS - 8'h01) begin
        level_d = sync_q[2];
        cnt_d   = 8'h00;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sync_q  <= 3'h0;
      cnt_q   <= 8'h00;
      level_q <= 1'b0;
    end else begin
      sync_q  <= sync_d;
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule : pmsq_deglitch

module pmsq_sequencer
#(
  parameter int                      TICK_CYCLES_P  = pmsq_pkg::TICK_CYCLES,
  parameter pmsq_pkg::pmsq_trigger_t BUTTON_TRIGGER = pmsq_pkg::PMSQ_TRIG_FALL
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        push_button_in,
  input  wire logic        adapter_supply_in,
  input  wire logic        usb_supply_detect,
  input  wire logic        host_power_ack_pin,
  input  wire logic        battery_above_lockout,
  input  wire logic        battery_above_alarm,
  input  wire logic        reg_write_en,
  input  wire logic [7:0]  reg_address,
  input  wire logic [7:0]  reg_write_data,
  output logic      [7:0]  reg_read_data,
  output logic             linear_rail_a_en,
  output logic             linear_rail_b_en,
  output logic             step_down_rail_a_en,
  output logic             step_down_rail_b_en,
  output logic             up_down_rail_en,
  output logic             host_reset_n_out,
  output logic             host_reset_n_oe_n,
  output logic             button_status_out,
  output logic             button_status_oe_n,
  output logic             bandgap_en,
  output pmsq_pkg::pmsq_state_t mode_out
);
  import pmsq_pkg::*;

  // ----------------------------------------------------------------
  // Millisecond tick and deglitched inputs
  // ----------------------------------------------------------------
  logic [15:0] presc_q, presc_d;
  logic        tick_q, tick_d;
  logic        btn_dg, adp_dg, usb_dg, ack_pin_dg, bat_ok, alarm_ok;

  always_comb begin
    tick_d  = 1'b0;
    presc_d = presc_q + 16'h0001;
    if (presc_q == 16'(TICK_CYCLES_P - 1)) begin
      presc_d = 16'h0000;
      tick_d  = 1'b1;
    end
  end

  pmsq_deglitch #(.TICKS(DEGLITCH_TICKS)) u_btn_dg (
    .clock(clock), .resetn(resetn), .tick(tick_q),
    .raw(push_button_in), .level(btn_dg));
  pmsq_deglitch #(.TICKS(DEGLITCH_TICKS)) u_adp_dg (
    .clock(clock), .resetn(resetn), .tick(tick_q),
    .raw(adapter_supply_in), .level(adp_dg));
  pmsq_deglitch #(.TICKS(DEGLITCH_TICKS)) u_usb_dg (
    .clock(clock), .resetn(resetn), .tick(tick_q),
    .raw(usb_supply_detect), .level(usb_dg));
  pmsq_deglitch #(.TICKS(ACK_DEGLITCH_TICKS)) u_ack_dg (
    .clock(clock), .resetn(resetn), .tick(tick_q),
    .raw(host_power_ack_pin), .level(ack_pin_dg));
  pmsq_deglitch #(.TICKS(NO_DEGLITCH_TICKS)) u_bat_sync (
    .clock(clock), .resetn(resetn), .tick(tick_q),
    .raw(battery_above_lockout), .level(bat_ok));
  pmsq_deglitch #(.TICKS(NO_DEGLITCH_TICKS)) u_alarm_sync (
    .clock(clock), .resetn(resetn), .tick(tick_q),
    .raw(battery_above_alarm), .level(alarm_ok));

  // ----------------------------------------------------------------
  // Mode machine, sequencing counter, register
  // ----------------------------------------------------------------
  pmsq_state_t state_q, state_d;
  logic [5:0]  cnt_q, cnt_d;
  logic        up_q, up_d;
  logic [7:0]  phase_q, phase_d;
  logic        acked_q, acked_d;
  logic        ack_bit_q, ack_bit_d;
  logic [3:0]  cause_q, cause_d;
  logic        usb_pend_q, usb_pend_d;
  logic        btn_prev_q, adp_prev_q, usb_prev_q;
  logic [4:0]  en_q, en_d;
  logic        bg_q, bg_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        btn_evt, adp_evt, usb_go, ext, ack_ok, wake;
  logic [3:0]  wake_cause;

  always_comb begin
    case (BUTTON_TRIGGER)
      PMSQ_TRIG_RISE: btn_evt = btn_dg & ~btn_prev_q;
      PMSQ_TRIG_FALL: btn_evt = ~btn_dg & btn_prev_q;
      PMSQ_TRIG_HIGH: btn_evt = btn_dg;
      default:        btn_evt = ~btn_dg;
    endcase
    adp_evt = adp_dg & ~adp_prev_q;
    usb_go  = usb_pend_q & alarm_ok;
    ext     = adp_dg | usb_dg;
    ack_ok  = ack_bit_q | ack_pin_dg;
    wake    = btn_evt | adp_evt | usb_go;
    wake_cause = 4'h0;
    if (adp_evt) begin
      wake_cause[CAUSE_ADAPTER_POS] = 1'b1;
    end else if (usb_go) begin
      wake_cause[CAUSE_USB_POS] = 1'b1;
    end else if (btn_evt) begin
      wake_cause[CAUSE_BUTTON_POS] = 1'b1;
    end
  end

  always_comb begin
    state_d    = state_q;
    phase_d    = phase_q;
    acked_d    = acked_q;
    cause_d    = cause_q;
    ack_bit_d  = ack_bit_q;
    usb_pend_d = (usb_pend_q | (usb_dg & ~usb_prev_q)) & usb_dg;
    up_d       = up_q;
    cnt_d      = cnt_q;
    if (tick_q && up_q && cnt_q != SEQ_TOP) begin
      cnt_d = cnt_q + 6'h01;
    end else if (tick_q && !up_q && cnt_q != SEQ_BOTTOM) begin
      cnt_d = cnt_q - 6'h01;
    end
    if (reg_write_en && reg_address == CAUSE_REG_OFFSET) begin
      ack_bit_d = reg_write_data[ACK_BIT_POS];
    end
    case (state_q)
      PMSQ_POWER_OFF, PMSQ_STANDBY, PMSQ_CHG_STANDBY: begin
        cause_d   = CAUSE_RESET;
        ack_bit_d = ACK_BIT_RESET;
        if (state_q == PMSQ_POWER_OFF && !wake && bat_ok) begin
          if (alarm_ok) begin
            state_d = PMSQ_SETTLE;
            phase_d = 8'h00;
            cause_d[CAUSE_BATTERY_POS] = 1'b1;
          end else begin
            state_d = PMSQ_STANDBY;
          end
        end else if (state_q == PMSQ_CHG_STANDBY && !ext) begin
          state_d = PMSQ_STANDBY;
        end else if (state_q != PMSQ_POWER_OFF && !bat_ok && !ext) begin
          state_d = PMSQ_POWER_OFF;
        end else if (wake && (bat_ok || ext)) begin
          state_d    = PMSQ_SETTLE;
          phase_d    = 8'h00;
          cause_d    = wake_cause;
          usb_pend_d = usb_pend_d & ~usb_go;
        end
      end
      PMSQ_SETTLE: begin
        if (tick_q) begin
          phase_d = phase_q + 8'h01;
          if (phase_q == SETTLE_TICKS - 8'h01) begin
            state_d = PMSQ_ACTIVE;
            phase_d = 8'h00;
            cnt_d   = SEQ_BOTTOM;
            up_d    = 1'b1;
            acked_d = 1'b0;
          end
        end
      end
      PMSQ_ACTIVE: begin
        if (!acked_q) begin
          if (ack_ok) begin
            acked_d = 1'b1;
          end else if (tick_q) begin
            phase_d = phase_q + 8'h01;
            if (phase_q == ACK_DEADLINE_TICKS - 8'h01) begin
              state_d = PMSQ_EXPIRE;
              phase_d = 8'h00;
            end
          end
        end else if (!ext && (!ack_ok || !alarm_ok)) begin
          state_d = PMSQ_POWER_DOWN;
          up_d    = 1'b0;
        end
      end
      PMSQ_POWER_DOWN: begin
        if (wake) begin
          state_d    = PMSQ_ACTIVE;
          up_d       = 1'b1;
          phase_d    = 8'h00;
          acked_d    = 1'b0;
          cause_d    = wake_cause;
          usb_pend_d = usb_pend_d & ~usb_go;
        end else if (tick_q && cnt_q == SEQ_BOTTOM) begin
          state_d = ext ? PMSQ_CHG_STANDBY : PMSQ_STANDBY;
        end
      end
      PMSQ_EXPIRE: begin
        if (tick_q) begin
          phase_d = phase_q + 8'h01;
          if (phase_q == EXPIRE_HOLD_TICKS - 8'h01) begin
            state_d = ext ? PMSQ_CHG_STANDBY : PMSQ_STANDBY;
            cnt_d   = SEQ_BOTTOM;
          end
        end
      end
      default: state_d = PMSQ_POWER_OFF;
    endcase
  end

  // Comparators keep their output between crossings, so a reversal
  // mid-sequence never glitches a rail that is already in place.
  always_comb begin
    for (int i = 0; i < NUM_SEQ_OUTPUTS; i++) begin
      if (state_q == PMSQ_ACTIVE || state_q == PMSQ_POWER_DOWN) begin
        if (up_q) begin
          en_d[i] = en_q[i] | (cnt_q > SEQ_DELAY[i]);
        end else begin
          en_d[i] = en_q[i] & ~(cnt_q < SEQ_DELAY[i]);
        end
      end else if (state_q == PMSQ_EXPIRE && i != RESET_OUTPUT_INDEX) begin
        en_d[i] = en_q[i];
      end else begin
        en_d[i] = 1'b0;
      end
    end
    bg_d = (state_d == PMSQ_SETTLE) || (state_d == PMSQ_ACTIVE) ||
           (state_d == PMSQ_POWER_DOWN) || (state_d == PMSQ_EXPIRE);
    rdata_d = UNMAPPED_READ;
    if (reg_address == CAUSE_REG_OFFSET) begin
      rdata_d = {3'h0, ack_bit_q, cause_q};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      presc_q    <= 16'h0000;
      tick_q     <= 1'b0;
      state_q    <= PMSQ_POWER_OFF;
      cnt_q      <= SEQ_BOTTOM;
      up_q       <= 1'b1;
      phase_q    <= 8'h00;
      acked_q    <= 1'b0;
      ack_bit_q  <= ACK_BIT_RESET;
      cause_q    <= CAUSE_RESET;
      usb_pend_q <= 1'b0;
      btn_prev_q <= 1'b0;
      adp_prev_q <= 1'b0;
      usb_prev_q <= 1'b0;
      en_q       <= 5'h00;
      bg_q       <= 1'b0;
      rdata_q    <= 8'h00;
    end else begin
      presc_q    <= presc_d;
      tick_q     <= tick_d;
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      up_q       <= up_d;
      phase_q    <= phase_d;
      acked_q    <= acked_d;
      ack_bit_q  <= ack_bit_d;
      cause_q    <= cause_d;
      usb_pend_q <= usb_pend_d;
      btn_prev_q <= btn_dg;
      adp_prev_q <= adp_dg;
      usb_prev_q <= usb_dg;
      en_q       <= en_d;
      bg_q       <= bg_d;
      rdata_q    <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs (open-drain pins drive low only; level held at zero)
  // ----------------------------------------------------------------
  assign reg_read_data       = rdata_q;
  assign linear_rail_a_en    = en_q[0];
  assign linear_rail_b_en    = en_q[0];
  assign step_down_rail_a_en = en_q[1];
  assign step_down_rail_b_en = en_q[2];
  assign up_down_rail_en     = en_q[3];
  assign host_reset_n_out    = 1'b0 & en_q[RESET_OUTPUT_INDEX];
  assign host_reset_n_oe_n   = en_q[RESET_OUTPUT_INDEX];
  assign button_status_out   = 1'b0 & btn_prev_q;
  assign button_status_oe_n  = btn_prev_q;
  assign bandgap_en          = bg_q;
  assign mode_out            = state_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  off_rails_dark_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_q == PMSQ_POWER_OFF || state_q == PMSQ_STANDBY) |=> en_q == 5'h00)
    else $error("Rail on while powered down");
  standby_brownout_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_q == PMSQ_STANDBY && !bat_ok && !ext) |=> state_q == PMSQ_POWER_OFF)
    else $error("Standby kept with battery below lockout");
  settle_end_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_q == PMSQ_SETTLE && tick_q && phase_q == SETTLE_TICKS - 8'h01)
    |=> (state_q == PMSQ_ACTIVE && cnt_q == SEQ_BOTTOM && up_q))
    else $error("Settle wait did not end into counting up");
  count_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_q == PMSQ_ACTIVE && up_q && cnt_q == SEQ_TOP && state_d == state_q)
    |=> cnt_q == SEQ_TOP)
    else $error("Counter left its terminal value");
  rail_on_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_q == PMSQ_ACTIVE && up_q && cnt_q > SEQ_DELAY[1])
    |=> step_down_rail_a_en)
    else $error("Step-down rail a not enabled past its delay");
  rail_off_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_q == PMSQ_POWER_DOWN && !up_q && cnt_q < SEQ_DELAY[3])
    |=> !up_down_rail_en)
    else $error("Up/down rail still on below its delay");
  reset_order_a: assert property (@(posedge clock) disable iff (!resetn)
    host_reset_n_oe_n |-> (linear_rail_a_en && up_down_rail_en))
    else $error("Reset released with a rail off");
  expiry_reset_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(state_q == PMSQ_EXPIRE) |=> !host_reset_n_oe_n)
    else $error("Reset not asserted on deadline expiry");
  cause_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_q == PMSQ_STANDBY && state_d == PMSQ_STANDBY) |=> cause_q == 4'h0)
    else $error("Wakeup cause kept while powered off");
  ack_write_a: assert property (@(posedge clock) disable iff (!resetn)
    (reg_write_en && reg_address == CAUSE_REG_OFFSET &&
     state_q == PMSQ_ACTIVE) |=> ##1 reg_read_data[ACK_BIT_POS] ==
     $past(reg_write_data[ACK_BIT_POS], 2))
    else $error("Acknowledge bit write not read back");

endmodule : pmsq_sequencer
`default_nettype wire

// ---- pkg/pmsq_pkg.sv ----
/*
 * Constants and types for the power mode sequencer.
 * Assumes a 25 MHz free-running system clock; all millisecond timing is
 * derived from a 1 ms tick produced by the sequencer itself.
 */
`default_nettype none
package pmsq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 25_000_000;
  localparam int TICK_HZ     = 1000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int TICK_MS     = 1;

  localparam int SETTLE_MS       = 5;
  localparam int DEGLITCH_MS     = 32;
  localparam int ACK_DEGLITCH_MS = 5;
  localparam int ACK_DEADLINE_MS = 128;
  localparam int EXPIRE_HOLD_MS  = 2;

  localparam logic [7:0] SETTLE_TICKS       = 8'(SETTLE_MS / TICK_MS);
  localparam logic [7:0] DEGLITCH_TICKS     = 8'(DEGLITCH_MS / TICK_MS);
  localparam logic [7:0] ACK_DEGLITCH_TICKS = 8'(ACK_DEGLITCH_MS / TICK_MS);
  localparam logic [7:0] ACK_DEADLINE_TICKS = 8'(ACK_DEADLINE_MS / TICK_MS);
  localparam logic [7:0] EXPIRE_HOLD_TICKS  = 8'(EXPIRE_HOLD_MS / TICK_MS);
  localparam logic [7:0] NO_DEGLITCH_TICKS  = 8'h00;

  // ----------------------------------------------------------------
  // Sequencing counter and factory output delays (ms)
  // ----------------------------------------------------------------
  localparam logic [5:0] SEQ_BOTTOM         = 6'h00;
  localparam logic [5:0] SEQ_TOP            = 6'h3F;
  localparam int         NUM_SEQ_OUTPUTS    = 5;
  localparam int         RESET_OUTPUT_INDEX = 4;
  // Linear rails, step-down a, step-down b, up/down rail, host reset.
  // Off delay is 64 minus these, compared against the same table entries.
  localparam logic [5:0] SEQ_DELAY [NUM_SEQ_OUTPUTS] =
    '{6'h05, 6'h0F, 6'h14, 6'h19, 6'h3C};

  // ----------------------------------------------------------------
  // Wakeup-cause register
  // ----------------------------------------------------------------
  localparam logic [7:0] CAUSE_REG_OFFSET  = 8'h00;
  localparam int         ACK_BIT_POS       = 4;
  localparam int         CAUSE_BATTERY_POS = 3;
  localparam int         CAUSE_BUTTON_POS  = 2;
  localparam int         CAUSE_ADAPTER_POS = 1;
  localparam int         CAUSE_USB_POS     = 0;
  localparam logic [3:0] CAUSE_RESET       = 4'h0;
  localparam logic       ACK_BIT_RESET     = 1'b0;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMSQ_TRIG_RISE  = 2'h0,
    PMSQ_TRIG_FALL  = 2'h1,
    PMSQ_TRIG_HIGH  = 2'h2,
    PMSQ_TRIG_LOW   = 2'h3
  } pmsq_trigger_t;

  typedef enum logic [2:0] {
    PMSQ_POWER_OFF   = 3'h0,
    PMSQ_STANDBY     = 3'h1,
    PMSQ_SETTLE      = 3'h3,
    PMSQ_ACTIVE      = 3'h2,
    PMSQ_POWER_DOWN  = 3'h6,
    PMSQ_CHG_STANDBY = 3'h7,
    PMSQ_EXPIRE      = 3'h5
  } pmsq_state_t;

endpackage : pmsq_pkg
`default_nettype wire

// ---- verif/pmsq_host_model.sv ----
/* Host processor model: raises its acknowledge pin once let out of reset.
   Assumes the sequencer's reset pin enable and the bench's ack controls. */
`timescale 1ns/1ns
`default_nettype none
module pmsq_host_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        host_reset_n_oe_n,
  input  wire logic        ack_en,
  input  wire logic [15:0] ack_wait,
  output logic             host_power_ack_pin
);
  logic [15:0] wait_q;

  // Held in reset, the host cannot answer; it lets go when told to
  always_ff @(posedge clock) begin
    if (!resetn || !host_reset_n_oe_n || !ack_en) begin
      wait_q             <= 16'h0000;
      host_power_ack_pin <= 1'b0;
    end else if (wait_q < ack_wait) begin
      wait_q <= wait_q + 16'h0001;
    end else begin
      host_power_ack_pin <= 1'b1;
    end
  end
endmodule : pmsq_host_model
`default_nettype wire

// ---- verif/testbench.sv ----
/* Self-checking bench for the power mode sequencer with a host model.
   Assumes pmsq_pkg compiled first; the tick is cut to 10 clocks. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pmsq_pkg::*;
  localparam int T = 10;
  logic        clock, resetn, push_button_in, adapter_supply_in, ack_en;
  logic        usb_supply_detect, battery_above_lockout, battery_above_alarm;
  logic        reg_write_en, linear_rail_a_en, linear_rail_b_en;
  logic [7:0]  reg_address, reg_write_data, reg_read_data;
  logic [15:0] ack_wait;
  logic        step_down_rail_a_en, step_down_rail_b_en, up_down_rail_en;
  logic        host_reset_n_out, host_reset_n_oe_n, button_status_out;
  logic        button_status_oe_n, bandgap_en, host_power_ack_pin;
  pmsq_state_t mode_out;
  int          n_mismatch, samples_checked, cycles, n;

  pmsq_sequencer #(.TICK_CYCLES_P(T)) pmsq_sequencer_i (
    .clock, .resetn, .push_button_in, .adapter_supply_in, .usb_supply_detect,
    .host_power_ack_pin, .battery_above_lockout, .battery_above_alarm,
    .reg_write_en, .reg_address, .reg_write_data, .reg_read_data,
    .linear_rail_a_en, .linear_rail_b_en, .step_down_rail_a_en,
    .step_down_rail_b_en, .up_down_rail_en, .host_reset_n_out,
    .host_reset_n_oe_n, .button_status_out, .button_status_oe_n, .bandgap_en,
    .mode_out);
  pmsq_host_model pmsq_host_model_i (.clock, .resetn, .host_reset_n_oe_n,
    .ack_en, .ack_wait, .host_power_ack_pin);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (exp !== got) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic check_time(string what, int lo, int hi, int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_time

  task automatic wait_mode(pmsq_state_t m, int lim);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (mode_out !== m && n < lim);
    check("mode", 8'(m), 8'(mode_out));
  endtask : wait_mode

  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    reg_address    <= a;
    reg_write_data <= d;
    reg_write_en   <= 1'b1;
    @(posedge clock);
    reg_write_en <= 1'b0;
  endtask : reg_wr

  task automatic reg_check(logic [7:0] a, logic [7:0] exp);
    @(posedge clock);
    reg_address <= a;
    @(posedge clock);
    @(negedge clock);
    check("read data", exp, reg_read_data);
  endtask : reg_check

  task automatic do_reset(logic lock, logic alarm);
    @(posedge clock);
    resetn                <= 1'b0;
    battery_above_lockout <= lock;
    battery_above_alarm   <= alarm;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
  endtask : do_reset

  function automatic logic out_bit(int i);
    case (i)
      0: return linear_rail_a_en;
      1: return step_down_rail_a_en;
      2: return step_down_rail_b_en;
      3: return up_down_rail_en;
      default: return host_reset_n_oe_n;
    endcase
  endfunction : out_bit

  // Tick phase against mode entry is unknown: one tick of slack each way
  task automatic seq_check(logic up);
    int seen [NUM_SEQ_OUTPUTS];
    int k;
    seen = '{default: -1};
    for (int c = 1; c <= 70 * T; c++) begin
      @(negedge clock);
      check("rail pair", 8'(linear_rail_a_en), 8'(linear_rail_b_en));
      for (int i = 0; i < NUM_SEQ_OUTPUTS; i++)
        if (seen[i] < 0 && out_bit(i) === up) seen[i] = c;
    end
    for (int i = 0; i < NUM_SEQ_OUTPUTS; i++) begin
      k = up ? SEQ_DELAY[i] + 1 : 64 - SEQ_DELAY[i];
      check_time($sformatf("output %0d", i), (k - 1) * T, (k + 1) * T, seen[i]);
    end
  endtask : seq_check

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_off;
    do_reset(1'b0, 1'b0);
    repeat (40 * T) @(negedge clock);
    check("mode", 8'(PMSQ_POWER_OFF), 8'(mode_out));
    check("reset pin", 8'h00, 8'(host_reset_n_oe_n));
    check("reset level", 8'h00, 8'(host_reset_n_out));
    check("status level", 8'h00, 8'(button_status_out));
    check("bandgap", 8'h00, 8'(bandgap_en));
    reg_wr(8'h00, 8'hFF);
    reg_wr(8'h05, 8'hFF);
    reg_check(8'h00, 8'h00);
    reg_check(8'h05, 8'h00);
    do_reset(1'b1, 1'b0);
    wait_mode(PMSQ_STANDBY, 10);
    @(posedge clock);
    battery_above_lockout <= 1'b0;
    wait_mode(PMSQ_POWER_OFF, 10);
    $display("test_off done");
  endtask : test_off

  task automatic test_battery;
    @(posedge clock);
    ack_en <= 1'b1;
    do_reset(1'b1, 1'b1);
    wait_mode(PMSQ_SETTLE, 10);
    check("bandgap", 8'h01, 8'(bandgap_en));
    wait_mode(PMSQ_ACTIVE, 6 * T);
    check_time("settle", 4 * T, 6 * T, n);
    seq_check(1'b1);
    reg_wr(8'h00, 8'h10);
    reg_check(8'h00, 8'h18);
    @(posedge clock);
    ack_en <= 1'b0;
    reg_wr(8'h00, 8'h00);
    wait_mode(PMSQ_POWER_DOWN, 8 * T);
    seq_check(1'b0);
    wait_mode(PMSQ_STANDBY, 3 * T);
    reg_check(8'h00, 8'h00);
    $display("test_battery done");
  endtask : test_battery

  task automatic test_button;
    @(posedge clock);
    push_button_in <= 1'b0;
    wait_mode(PMSQ_SETTLE, 40 * T);
    check_time("deglitch", 31 * T, 34 * T, n);
    check("status", 8'h00, 8'(button_status_oe_n));
    reg_check(8'h00, 8'h04);
    wait_mode(PMSQ_ACTIVE, 6 * T);
    wait_mode(PMSQ_EXPIRE, 135 * T);
    check_time("deadline", 127 * T, 130 * T, n);
    repeat (T / 2) @(negedge clock);
    check("reset pin", 8'h00, 8'(host_reset_n_oe_n));
    check("rail", 8'h01, 8'(up_down_rail_en));
    wait_mode(PMSQ_STANDBY, 3 * T);
    // Rails drop on the edge after the mode word shows standby
    @(negedge clock);
    check("rail", 8'h00, 8'(linear_rail_a_en));
    @(posedge clock);
    push_button_in <= 1'b1;
    repeat (40 * T) @(negedge clock);
    check("mode", 8'(PMSQ_STANDBY), 8'(mode_out));
    $display("test_button done");
  endtask : test_button

  task automatic test_usb;
    @(posedge clock);
    battery_above_alarm <= 1'b0;
    usb_supply_detect   <= 1'b1;
    repeat (40 * T) @(negedge clock);
    check("mode", 8'(PMSQ_STANDBY), 8'(mode_out));
    @(posedge clock);
    battery_above_alarm <= 1'b1;
    wait_mode(PMSQ_SETTLE, 10);
    reg_check(8'h00, 8'h01);
    wait_mode(PMSQ_CHG_STANDBY, 140 * T);
    $display("test_usb done");
  endtask : test_usb

  task automatic test_adapter;
    @(posedge clock);
    ack_en            <= 1'b1;
    usb_supply_detect <= 1'b0;
    do_reset(1'b0, 1'b0);
    @(posedge clock);
    adapter_supply_in <= 1'b1;
    wait_mode(PMSQ_SETTLE, 40 * T);
    wait_mode(PMSQ_ACTIVE, 6 * T);
    seq_check(1'b1);
    reg_check(8'h00, 8'h02);
    @(posedge clock);
    ack_en <= 1'b0;
    reg_wr(8'h00, 8'h00);
    repeat (20 * T) @(negedge clock);
    check("mode", 8'(PMSQ_ACTIVE), 8'(mode_out));
    @(posedge clock);
    adapter_supply_in <= 1'b0;
    wait_mode(PMSQ_POWER_DOWN, 40 * T);
    repeat (10 * T) @(posedge clock);
    adapter_supply_in <= 1'b1;
    wait_mode(PMSQ_ACTIVE, 40 * T);
    check("rail", 8'h01, 8'(linear_rail_a_en));
    repeat (12 * T) @(negedge clock);
    check("rail", 8'h01, 8'(up_down_rail_en));
    $display("test_adapter done");
  endtask : test_adapter

  initial begin
    {resetn, reg_write_en, ack_en, adapter_supply_in, usb_supply_detect} = '0;
    {battery_above_lockout, battery_above_alarm, push_button_in} = 3'h1;
    {reg_address, reg_write_data, ack_wait} = 32'h0000_0003;
    {cycles, n_mismatch, samples_checked} = '0;
    test_off();
    test_battery();
    test_button();
    test_usb();
    test_adapter();
    final_report();
  end
endmodule : testbench
`default_nettype wire
